// *** sfc_pkg.sv ***
// Overview of operation
// - protect codes 1..6 guard the top 1,2,4,8,16,32 blocks
// - code 0 guards none; 7,8,15 all; 9..14 bottom 32..63 blocks
// - guard pin protects protect-level and status-write-lock bits in pin mode
// - four-line mode disables pin protect mode, the pin carries data
// - separate 4K-bit one-time area holds the unique identifier
// - offsets 000..00F hold factory serial number, 010..1FF customer data
// - security word bit 0 reports the factory lock
// - set-customer-lock command sets security word bit 1
// - a set lock never clears or changes again
// - main array access refused while secure area mode is active
// - 24-bit address space, 64 blocks of 16 sectors of 1000h bytes
// - invalid command: standby, output lines released until chip select rises
// - valid command: active until chip select rises
// - sample on rising clock, change output on falling; modes 0 and 3
// - read-type commands end whenever chip select rises
// - modifying commands need chip select rise on a byte boundary
// - array access ignored while an operation runs
// - opcode 06h sets the write latch, 04h clears it
// - 9Fh gives three ident bytes, 05h status, 01h writes status
// - 03h takes three address bytes then data; 0Bh adds one dummy byte
// - BBh uses two lines, EBh four lines with dummy clocks
// - op_running reads one while program, erase or status write runs
// - status write lock high and pin low refuse status writes
// - four_line_enable one selects four lines and drops pin protection; EBh uses four lines whatever its value
// - program or erase on protected area ignored, write latch kept
package sfc_pkg;
  localparam logic [7:0] OPC_SET_WL = 8'h06;
  localparam logic [7:0] OPC_CLR_WL = 8'h04;
  localparam logic [7:0] OPC_IDENT = 8'h9F;
  localparam logic [7:0] OPC_RD_STATE = 8'h05;
  localparam logic [7:0] OPC_WR_STATE = 8'h01;
  localparam logic [7:0] OPC_READ = 8'h03;
  localparam logic [7:0] OPC_FAST = 8'h0B;
  localparam logic [7:0] OPC_DUAL = 8'hBB;
  localparam logic [7:0] OPC_QUAD = 8'hEB;
  localparam logic [7:0] OPC_PAGE = 8'h02;
  localparam logic [7:0] OPC_SECT = 8'h20;
  localparam logic [7:0] OPC_BLOCK = 8'hD8;
  localparam logic [7:0] OPC_CHIP_A = 8'h60;
  localparam logic [7:0] OPC_CHIP_B = 8'hC7;
  localparam logic [7:0] OPC_ENTER_SA = 8'hB1;
  localparam logic [7:0] OPC_EXIT_SA = 8'hC1;
  localparam logic [7:0] OPC_RD_SEC = 8'h2B;
  localparam logic [7:0] OPC_CUST_LOCK = 8'h2F;
  localparam int SR_OP_RUNNING = 0;
  localparam int SR_WRITE_LATCH = 1;
  localparam int SR_LEVEL_LO = 2;
  localparam int SR_FOUR_LINE = 6;
  localparam int SR_WRITE_LOCK = 7;
  localparam logic [7:0] SR_RESET = 8'h0C;
  localparam logic [5:0] SR_NV_MASK = 6'h3F;
  localparam logic [8:0] ESN_LAST = 9'h00F;
  localparam logic [23:0] ADDR_LAST = 24'h3FFFFF;
  localparam logic [23:0] SECTOR_MASK = 24'hFFF000;
  localparam logic [23:0] BLOCK_MASK = 24'hFF0000;
  localparam logic [7:0] BLOCK_COUNT = 8'h40;
  localparam logic [2:0] ADDR_BYTES = 3'h3;
  localparam logic [2:0] DUMMY_FAST = 3'h1;
  localparam logic [2:0] DUMMY_DUAL = 3'h1;
  localparam logic [2:0] DUMMY_QUAD = 3'h3;
  localparam logic [2:0] LANES_1 = 3'h1;
  localparam logic [2:0] LANES_2 = 3'h2;
  localparam logic [2:0] LANES_4 = 3'h4;
  localparam logic [3:0] BYTES_CMD = 4'h1;
  localparam logic [3:0] BYTES_WR_STATE = 4'h2;
  localparam logic [3:0] BYTES_ERASE = 4'h4;
  localparam logic [3:0] BYTES_PAGE_MIN = 4'h5;

  typedef enum logic [5:0] {
    ST_CMD = 6'h01, ST_ADDR = 6'h02, ST_DUMMY = 6'h04,
    ST_WDATA = 6'h08, ST_OUT = 6'h10, ST_IGNORE = 6'h20
  } lnk_st_t;
  typedef enum logic [2:0] {
    OP_NONE = 3'h0, OP_PGM = 3'h1, OP_SECT = 3'h2, OP_BLOCK = 3'h3, OP_CHIP = 3'h4, OP_STATE = 3'h5
  } op_kind_t;
  typedef struct packed {
    logic req;
    op_kind_t kind;
    logic otp;
    logic [23:0] addr;
  } op_req_t;
  typedef struct packed {
    lnk_st_t st;
    logic active;
    logic [2:0] bitpos;
    logic [2:0] lanes;
    logic [2:0] nbytes;
    logic [7:0] op;
    logic [7:0] sh;
    logic [23:0] addr;
    logic [10:0] cs1;
    logic [10:0] cs2;
  } lnk_t;
  typedef struct packed {
    logic tog;
    logic ok;
    logic boundary;
    logic [3:0] bytes;
    logic [7:0] op;
    logic [7:0] data;
    logic [23:0] addr;
  } rec_t;
  typedef struct packed {
    logic [7:0] osh;
    logic [3:0] sio;
    logic [3:0] oe;
  } drv_t;
  typedef struct packed {
    logic cs1, cs2, cs3;
    logic tg1, tg2, seen;
    logic wp1, wp2;
    logic loaded;
    logic flock;
    logic clock;
    logic secure;
    logic [7:0] sr;
    op_req_t op;
  } core_t;
endpackage : sfc_pkg

// *** serial_flash_cmd_protect.sv ***
`timescale 1ns/1ns
module serial_flash_cmd_protect #(
  parameter logic [7:0] MFR_CODE = 8'hA5, // arbitrary value
  parameter logic [7:0] TYPE_CODE = 8'h3C, // arbitrary value
  parameter logic [7:0] DEV_CODE = 8'h17 // arbitrary value
) (
  input wire logic I_REF_CLK,
  input wire logic I_RST,
  input wire logic I_SCLK,
  input wire logic I_CS_N,
  input wire logic [3:0] I_SIO,
  output logic [3:0] O_SIO,
  output logic [3:0] O_SIO_OE,
  input wire logic [7:0] I_RD_DATA,
  output logic [23:0] O_RD_ADDR,
  output logic O_RD_OTP,
  output logic O_ACTIVE,
  input wire logic I_OP_DONE,
  input wire logic I_FACTORY_LOCK,
  input wire logic I_CUSTOMER_LOCK,
  output logic [7:0] O_STATUS,
  output logic O_SEC_MODE,
  output sfc_pkg::op_req_t O_OP
);
  // ----------------------------------------------------------------
  // protection decode
  // ----------------------------------------------------------------
  function automatic logic prot(input logic [3:0] lvl, input logic [7:0] blk);
    logic r;
    r = 1'b0;
    if (blk >= sfc_pkg::BLOCK_COUNT) begin
      r = 1'b1;
    end else if (lvl >= 4'h1 && lvl <= 4'h6) begin
      r = blk >= (sfc_pkg::BLOCK_COUNT - (8'h01 << (lvl - 4'h1)));
    end else if (lvl >= 4'h9 && lvl <= 4'hE) begin
      r = blk < (sfc_pkg::BLOCK_COUNT - (8'h01 << (4'hE - lvl)));
    end else if (lvl != 4'h0) begin
      r = 1'b1;
    end
    return r;
  endfunction : prot

  sfc_pkg::lnk_t l, ln;
  sfc_pkg::rec_t rc, rn;
  sfc_pkg::drv_t w, wn;
  sfc_pkg::core_t q, c;
  logic lnk_rst;
  logic [7:0] inb;
  logic [3:0] bsum;
  logic done;
  logic [7:0] obyte;
  logic [7:0] src;
  logic pin_protect_mode;
  logic exec;
  logic pe_try;
  logic refuse;
  logic [23:0] tgt;
  sfc_pkg::op_kind_t kind;

  assign lnk_rst = I_RST | I_CS_N;

  // ----------------------------------------------------------------
  // link side: command, address and dummy phases on rising edges
  // ----------------------------------------------------------------
  always_comb begin
    ln = l;
    ln.cs1 = {q.sr, q.clock, q.flock, q.secure};
    ln.cs2 = l.cs1;
    case (l.lanes)
      sfc_pkg::LANES_2: inb = {l.sh[5:0], I_SIO[1:0]};
      sfc_pkg::LANES_4: inb = {l.sh[3:0], I_SIO};
      default: inb = {l.sh[6:0], I_SIO[0]};
    endcase
    bsum = {1'b0, l.bitpos} + {1'b0, l.lanes};
    done = bsum[3];
    ln.sh = inb;
    ln.bitpos = bsum[2:0];
    if (done && l.nbytes != 3'h7) begin
      ln.nbytes = l.nbytes + 3'h1;
    end
    case (l.st)
      sfc_pkg::ST_CMD: begin
        if (done) begin
          ln.op = inb;
          ln.nbytes = 3'h0;
          ln.active = 1'b1;
          // snapshot holds {status, customer lock, factory lock, secure}: busy flag sits above the low three bits
          if (l.cs2[3 + sfc_pkg::SR_OP_RUNNING] && inb != sfc_pkg::OPC_RD_STATE && inb != sfc_pkg::OPC_RD_SEC) begin
            ln.st = sfc_pkg::ST_IGNORE;
            ln.active = 1'b0;
          end else begin
            case (inb)
              sfc_pkg::OPC_SET_WL, sfc_pkg::OPC_CLR_WL, sfc_pkg::OPC_WR_STATE, sfc_pkg::OPC_CHIP_A,
              sfc_pkg::OPC_CHIP_B, sfc_pkg::OPC_ENTER_SA, sfc_pkg::OPC_EXIT_SA,
              sfc_pkg::OPC_CUST_LOCK: ln.st = sfc_pkg::ST_WDATA;
              sfc_pkg::OPC_RD_STATE, sfc_pkg::OPC_IDENT, sfc_pkg::OPC_RD_SEC: ln.st = sfc_pkg::ST_OUT;
              sfc_pkg::OPC_READ, sfc_pkg::OPC_FAST, sfc_pkg::OPC_PAGE, sfc_pkg::OPC_SECT,
              sfc_pkg::OPC_BLOCK: ln.st = sfc_pkg::ST_ADDR;
              sfc_pkg::OPC_DUAL: begin
                ln.st = sfc_pkg::ST_ADDR;
                ln.lanes = sfc_pkg::LANES_2;
              end
              sfc_pkg::OPC_QUAD: begin
                ln.st = sfc_pkg::ST_ADDR;
                ln.lanes = sfc_pkg::LANES_4;
              end
              default: begin
                ln.st = sfc_pkg::ST_IGNORE;
                ln.active = 1'b0;
              end
            endcase
          end
        end
      end
      sfc_pkg::ST_ADDR: begin
        if (done) begin
          ln.addr = {l.addr[15:0], inb};
          if (l.nbytes == sfc_pkg::ADDR_BYTES - 3'h1) begin
            ln.nbytes = 3'h0;
            case (l.op)
              sfc_pkg::OPC_READ: ln.st = sfc_pkg::ST_OUT;
              sfc_pkg::OPC_FAST, sfc_pkg::OPC_DUAL, sfc_pkg::OPC_QUAD: ln.st = sfc_pkg::ST_DUMMY;
              default: ln.st = sfc_pkg::ST_WDATA;
            endcase
          end
        end
      end
      sfc_pkg::ST_DUMMY: begin
        if (done && (l.nbytes + 3'h1 == (l.op == sfc_pkg::OPC_QUAD ? sfc_pkg::DUMMY_QUAD :
            (l.op == sfc_pkg::OPC_DUAL ? sfc_pkg::DUMMY_DUAL : sfc_pkg::DUMMY_FAST)))) begin
          ln.st = sfc_pkg::ST_OUT;
          ln.nbytes = 3'h0;
        end
      end
      sfc_pkg::ST_OUT: begin
        ln.sh = l.sh;
        if (done) begin
          ln.addr = l.addr + 24'h000001;
        end
      end
      sfc_pkg::ST_WDATA: ln.st = sfc_pkg::ST_WDATA;
      sfc_pkg::ST_IGNORE: ln.st = sfc_pkg::ST_IGNORE;
      default: ln.st = sfc_pkg::ST_IGNORE;
    endcase
  end

  always_ff @(posedge I_SCLK or posedge lnk_rst) begin
    if (lnk_rst) begin
      l <= '{st: sfc_pkg::ST_CMD, lanes: sfc_pkg::LANES_1, default: '0};
    end else begin
      l <= ln;
    end
  end

  // ----------------------------------------------------------------
  // frame record: survives chip select rise for the core to execute
  // ----------------------------------------------------------------
  always_comb begin
    rn = rc;
    if (l.st == sfc_pkg::ST_CMD && l.bitpos == 3'h0) begin
      rn.tog = ~rc.tog;
      rn.bytes = 4'h0;
      rn.ok = 1'b0;
    end
    rn.boundary = (ln.bitpos == 3'h0);
    if (done) begin
      if (rn.bytes != 4'hF) begin
        rn.bytes = rn.bytes + 4'h1;
      end
      if (l.st == sfc_pkg::ST_CMD) begin
        rn.op = inb;
        rn.ok = (ln.st != sfc_pkg::ST_IGNORE);
      end
      if (l.st == sfc_pkg::ST_ADDR) begin
        rn.addr = ln.addr;
      end
      if (l.st == sfc_pkg::ST_WDATA && l.nbytes == 3'h0) begin
        rn.data = inb;
      end
    end
  end

  always_ff @(posedge I_SCLK or posedge I_RST) begin
    if (I_RST) begin
      rc <= '0;
    end else begin
      rc <= rn;
    end
  end

  // ----------------------------------------------------------------
  // link side: output lines change on falling edges
  // ----------------------------------------------------------------
  always_comb begin
    case (l.op)
      sfc_pkg::OPC_RD_STATE: obyte = l.cs2[10:3];
      sfc_pkg::OPC_RD_SEC: obyte = {6'h00, l.cs2[2:1]};
      sfc_pkg::OPC_IDENT: begin
        case (l.nbytes)
          3'h0: obyte = MFR_CODE;
          3'h1: obyte = TYPE_CODE;
          3'h2: obyte = DEV_CODE;
          default: obyte = 8'h00;
        endcase
      end
      default: obyte = I_RD_DATA;
    endcase
    src = (l.bitpos == 3'h0) ? obyte : w.osh;
    wn = w;
    wn.oe = 4'h0;
    if (l.st == sfc_pkg::ST_OUT) begin
      wn.osh = src << l.lanes;
      case (l.lanes)
        sfc_pkg::LANES_2: begin
          wn.sio = {2'b00, src[7:6]};
          wn.oe = 4'h3;
        end
        sfc_pkg::LANES_4: begin
          wn.sio = src[7:4];
          wn.oe = 4'hF;
        end
        default: begin
          wn.sio = {2'b00, src[7], 1'b0};
          wn.oe = 4'h2;
        end
      endcase
    end
  end

  always_ff @(negedge I_SCLK or posedge lnk_rst) begin
    if (lnk_rst) begin
      w <= '0;
    end else begin
      w <= wn;
    end
  end

  assign O_SIO = w.sio;
  assign O_SIO_OE = w.oe;
  assign O_RD_ADDR = l.addr;
  assign O_RD_OTP = l.cs2[0];
  assign O_ACTIVE = l.active;

  // ----------------------------------------------------------------
  // core side: execution at chip select rise
  // ----------------------------------------------------------------
  assign pin_protect_mode = q.sr[sfc_pkg::SR_WRITE_LOCK] & ~q.wp2 & ~q.sr[sfc_pkg::SR_FOUR_LINE];
  assign exec = q.cs2 & ~q.cs3 & (q.tg2 != q.seen) & rc.ok & rc.boundary;

  always_comb begin
    c = q;
    c.cs1 = I_CS_N;
    c.cs2 = q.cs1;
    c.cs3 = q.cs2;
    c.tg1 = rc.tog;
    c.tg2 = q.tg1;
    c.wp1 = I_SIO[2];
    c.wp2 = q.wp1;
    c.op.req = 1'b0;
    pe_try = 1'b0;
    refuse = 1'b0;
    kind = sfc_pkg::OP_NONE;
    tgt = rc.addr;
    if (!q.loaded) begin
      c.loaded = 1'b1;
      c.flock = I_FACTORY_LOCK;
      c.clock = I_CUSTOMER_LOCK;
    end
    if (I_OP_DONE) begin
      c.sr[sfc_pkg::SR_OP_RUNNING] = 1'b0;
    end
    if (q.cs2 && !q.cs3) begin
      c.seen = q.tg2;
    end
    case (rc.op)
      sfc_pkg::OPC_PAGE: begin
        kind = sfc_pkg::OP_PGM;
        pe_try = rc.bytes >= sfc_pkg::BYTES_PAGE_MIN;
      end
      sfc_pkg::OPC_SECT: begin
        kind = sfc_pkg::OP_SECT;
        pe_try = rc.bytes == sfc_pkg::BYTES_ERASE;
        tgt = rc.addr & sfc_pkg::SECTOR_MASK;
      end
      sfc_pkg::OPC_BLOCK: begin
        kind = sfc_pkg::OP_BLOCK;
        pe_try = rc.bytes == sfc_pkg::BYTES_ERASE;
        tgt = rc.addr & sfc_pkg::BLOCK_MASK;
      end
      sfc_pkg::OPC_CHIP_A, sfc_pkg::OPC_CHIP_B: begin
        kind = sfc_pkg::OP_CHIP;
        pe_try = rc.bytes == sfc_pkg::BYTES_CMD;
        tgt = 24'h000000;
      end
      default: kind = sfc_pkg::OP_NONE;
    endcase
    if (q.secure) begin
      refuse = (kind != sfc_pkg::OP_PGM) | q.clock | (q.flock & (rc.addr[8:0] <= sfc_pkg::ESN_LAST));
      tgt = {15'h0000, rc.addr[8:0]};
    end else if (kind == sfc_pkg::OP_CHIP) begin
      refuse = q.sr[5:2] != 4'h0;
    end else begin
      refuse = (rc.addr > sfc_pkg::ADDR_LAST) | prot(q.sr[5:2], rc.addr[23:16]);
    end
    pe_try = pe_try & exec & ~q.sr[sfc_pkg::SR_OP_RUNNING] & q.sr[sfc_pkg::SR_WRITE_LATCH];
    if (exec && !q.sr[sfc_pkg::SR_OP_RUNNING]) begin
      case (rc.op)
        sfc_pkg::OPC_SET_WL: if (rc.bytes == sfc_pkg::BYTES_CMD) c.sr[sfc_pkg::SR_WRITE_LATCH] = 1'b1;
        sfc_pkg::OPC_CLR_WL: if (rc.bytes == sfc_pkg::BYTES_CMD) c.sr[sfc_pkg::SR_WRITE_LATCH] = 1'b0;
        sfc_pkg::OPC_WR_STATE: begin
          if (rc.bytes == sfc_pkg::BYTES_WR_STATE && q.sr[sfc_pkg::SR_WRITE_LATCH] && !pin_protect_mode) begin
            c.sr[7:2] = rc.data[7:2] & sfc_pkg::SR_NV_MASK;
            c.sr[1:0] = 2'b01;
            c.op = '{req: 1'b1, kind: sfc_pkg::OP_STATE, otp: 1'b0, addr: 24'h000000};
          end
        end
        sfc_pkg::OPC_ENTER_SA: if (rc.bytes == sfc_pkg::BYTES_CMD) c.secure = 1'b1;
        sfc_pkg::OPC_EXIT_SA: if (rc.bytes == sfc_pkg::BYTES_CMD) c.secure = 1'b0;
        sfc_pkg::OPC_CUST_LOCK: if (rc.bytes == sfc_pkg::BYTES_CMD) c.clock = 1'b1;
        default: begin
          if (pe_try && !refuse) begin
            c.sr[1:0] = 2'b01;
            c.op = '{req: 1'b1, kind: kind, otp: q.secure, addr: tgt};
          end
        end
      endcase
    end
  end

  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      q <= '{cs1: 1'b1, cs2: 1'b1, cs3: 1'b1, sr: sfc_pkg::SR_RESET, default: '0};
    end else begin
      q <= c;
    end
  end

  assign O_STATUS = q.sr;
  assign O_SEC_MODE = q.secure;
  assign O_OP = q.op;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_prot_range;
    @(posedge I_REF_CLK) disable iff (I_RST)
      q.op.req && !q.op.otp && q.op.kind != sfc_pkg::OP_STATE |-> !prot(q.sr[5:2], q.op.addr[23:16]);
  endproperty
  a_prot_range: assert property (p_prot_range) else $error("launch into protected block");

  property p_pin_mode;
    @(posedge I_REF_CLK) disable iff (I_RST)
      q.op.req && q.op.kind == sfc_pkg::OP_STATE |-> !$past(pin_protect_mode);
  endproperty
  a_pin_mode: assert property (p_pin_mode) else $error("status write in pin protect mode");

  property p_locks;
    @(posedge I_REF_CLK) disable iff (I_RST)
      $past(q.loaded) |-> q.flock == $past(q.flock) && (q.clock || !$past(q.clock));
  endproperty
  a_locks: assert property (p_locks) else $error("lock bit changed");

  property p_secure;
    @(posedge I_REF_CLK) disable iff (I_RST)
      q.op.req |-> q.op.otp == q.secure && (!q.secure || q.op.kind == sfc_pkg::OP_PGM);
  endproperty
  a_secure: assert property (p_secure) else $error("array operation in secure area mode");

  property p_busy;
    @(posedge I_REF_CLK) disable iff (I_RST)
      q.op.req && !I_OP_DONE |=> q.sr[0] && !q.op.req;
  endproperty
  a_busy: assert property (p_busy) else $error("busy flag not set after launch");

  property p_busy_end;
    @(posedge I_REF_CLK) disable iff (I_RST)
      $fell(q.sr[0]) |-> $past(I_OP_DONE);
  endproperty
  a_busy_end: assert property (p_busy_end) else $error("busy cleared without done");

  property p_refused_latch;
    @(posedge I_REF_CLK) disable iff (I_RST)
      pe_try && refuse |=> !q.op.req && q.sr[1];
  endproperty
  a_refused_latch: assert property (p_refused_latch) else $error("refused operation touched latch");

  property p_boundary;
    @(posedge I_REF_CLK) disable iff (I_RST)
      q.op.req |-> $past(rc.boundary, 1) && $past(q.sr[1], 1);
  endproperty
  a_boundary: assert property (p_boundary) else $error("launch without boundary or latch");

  property p_standby;
    @(negedge I_SCLK) disable iff (lnk_rst)
      l.st == sfc_pkg::ST_IGNORE |-> w.oe == 4'h0 && !l.active;
  endproperty
  a_standby: assert property (p_standby) else $error("lines driven in standby");
endmodule : serial_flash_cmd_protect

// *** host_link_model.sv ***
`timescale 1ns/1ns
module host_link_model (
  output logic o_sclk,
  output logic o_cs_n,
  output logic [3:0] o_sio,
  input wire logic [3:0] i_sio,
  input wire logic i_active,
  input wire logic [3:0] i_oe
);
  logic mode3 = 1'h0;
  logic wp = 1'h1;
  logic act_seen;
  logic oe_seen;
  initial begin
    o_sclk = 1'h0;
    // late update so the device sees a rising edge on its link reset at start-up
    o_cs_n <= 1'h1;
    o_sio = 4'h5;
  end
  // ----------------------------------------
  // one link clock: fall, drive, rise, sample
  // ----------------------------------------
  task automatic tick(input logic [3:0] d, output logic [3:0] q);
    o_sclk = 1'h0;
    o_sio = d;
    #62 o_sclk = 1'h1;
    q = i_sio;
    // decode results settle after the rising edge, so look late in the high phase
    #63;
    act_seen = i_active;
    oe_seen = |i_oe;
  endtask : tick
  // opcode at tx msb, then tail on ln lines, dm dummy clocks, nr bytes back
  task automatic frame(input logic [39:0] tx, input int nb, input int ln, input int dm, input int nr,
                       output logic [31:0] rx);
    logic [3:0] q;
    int i;
    rx = 32'h0;
    i = 0;
    o_cs_n = 1'h0;
    #20;
    while (i < nb) begin
      if (i < 8 || ln == 1) begin
        tick({1'h1, wp, 1'h0, tx[39-i]}, q);
        i++;
      end else if (ln == 2) begin
        tick({1'h1, wp, tx[39-i], tx[38-i]}, q);
        i += 2;
      end else begin
        tick(tx[39-i -: 4], q);
        i += 4;
      end
    end
    repeat (dm) tick({1'h1, wp, 2'h0}, q);
    repeat (nr * 8 / ln) begin
      // released lines toggle so a stale level never reads as data
      tick(~o_sio, q);
      rx = (ln == 1) ? {rx[30:0], q[1]} : (ln == 2) ? {rx[29:0], q[1:0]} : {rx[27:0], q};
    end
    o_sclk = mode3;
    #62 o_cs_n = 1'h1;
    // guard pin keeps its level between frames, the data lines toggle
    o_sio = {~o_sio[3], wp, ~o_sio[1:0]};
  endtask : frame
endmodule : host_link_model

// *** test_serial_flash_cmd_protect.sv ***
`timescale 1ns/1ns
module test_serial_flash_cmd_protect;
  localparam logic [7:0] MFR = 8'h5A; // arbitrary value
  localparam logic [7:0] TYP = 8'hC3; // arbitrary value
  localparam logic [7:0] DEV = 8'h71; // arbitrary value
  logic clk = 1'h0;
  logic rst = 1'h0;
  logic op_done = 1'h0;
  logic [7:0] rd_data = 8'h00;
  logic [7:0] key;
  logic [7:0] sr;
  logic sa = 1'h0;
  logic cust = 1'h0;
  logic [31:0] rx;
  logic [23:0] a;
  logic [7:0] rdop [4] = '{8'h03, 8'h0B, 8'hBB, 8'hEB};
  int rdln [4] = '{1, 1, 2, 4};
  int rddm [4] = '{0, 8, 4, 6};
  int fail_count = 0;
  int checks_done = 0;
  int op_cnt = 0;
  int nops = 0;
  sfc_pkg::op_req_t last_op;
  sfc_pkg::op_req_t op;
  wire sclk, cs_n, rd_otp, active, sec;
  wire [3:0] hsio, dsio, oe, sio;
  wire [23:0] rd_addr;
  wire [7:0] status;
  assign sio = (oe & dsio) | (~oe & hsio);
  always #20 clk = ~clk;
  host_link_model h (.o_sclk(sclk), .o_cs_n(cs_n), .o_sio(hsio), .i_sio(sio), .i_active(active), .i_oe(oe));
  serial_flash_cmd_protect #(.MFR_CODE(MFR), .TYPE_CODE(TYP), .DEV_CODE(DEV)) DUT (
    .I_REF_CLK(clk), .I_RST(rst), .I_SCLK(sclk), .I_CS_N(cs_n), .I_SIO(sio), .O_SIO(dsio),
    .O_SIO_OE(oe), .I_RD_DATA(rd_data), .O_RD_ADDR(rd_addr), .O_RD_OTP(rd_otp), .O_ACTIVE(active),
    .I_OP_DONE(op_done), .I_FACTORY_LOCK(1'h1), .I_CUSTOMER_LOCK(1'h0), .O_STATUS(status),
    .O_SEC_MODE(sec), .O_OP(op));
  // ----------------------------------------
  // memory stand-in, launch monitor, helpers
  // ----------------------------------------
  function automatic logic [7:0] mem(input logic [23:0] x, input logic t);
    return x[7:0] ^ x[15:8] ^ x[23:16] ^ key ^ {7'h0, t};
  endfunction : mem
  function automatic logic prot(input int c, input int b);
    if (c == 0) return 1'h0;
    if (c < 7) return b >= 64 - (1 << (c - 1));
    if (c == 7 || c == 8 || c == 15) return 1'h1;
    return b < 64 - (1 << (14 - c));
  endfunction : prot
  always @(posedge clk) begin
    rd_data <= mem(rd_addr, rd_otp);
    if (op.req === 1'h1) begin
      op_cnt <= op_cnt + 1;
      last_op <= op;
    end
  end
  task automatic print_verdict;
    $display("comparisons %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic f(input logic [39:0] tx, input int nb, input int ln = 1, input int dm = 0, input int nr = 0);
    h.frame(tx, nb, ln, dm, nr, rx);
    repeat (8) @(posedge clk);
    #1;
  endtask : f
  task automatic c1(input logic [7:0] o);
    f({o, 32'h0}, 8);
  endtask : c1
  task automatic fin(input logic ok);
    if (ok) begin
      @(posedge clk) op_done <= 1'h1;
      @(posedge clk) op_done <= 1'h0;
      repeat (4) @(posedge clk);
      #1;
      sr[0] = 1'h0;
    end else begin
      c1(8'h04);
      sr[1] = 1'h0;
    end
    chk(status, sr);
  endtask : fin
  task automatic wrs(input logic [7:0] v);
    logic ok;
    ok = !(sr[7] && !h.wp && !sr[6]);
    c1(8'h06);
    sr[1] = 1'h1;
    f({8'h01, v, 24'h0}, 16);
    if (ok) begin
      sr = {v[7:2], 2'h1};
      nops++;
    end
    chk(op_cnt, nops);
    chk(status, sr);
    fin(ok);
  endtask : wrs
  task automatic er(input int b);
    logic p;
    a = {2'h0, b[5:0], 16'h0000} | (24'($urandom) & 24'h00FFFF);
    p = prot(sr[5:2], b) || sa;
    c1(8'h06);
    sr[1] = 1'h1;
    f({8'h20, a, 8'h0}, 32);
    if (!p) begin
      nops++;
      sr[1:0] = 2'h1;
      chk(last_op, {1'h1, sfc_pkg::OP_SECT, 1'h0, a & sfc_pkg::SECTOR_MASK});
      c1(8'h06);
      chk(h.act_seen, 1'h0);
      f({8'h05, 32'h0}, 8, 1, 0, 1);
      chk(rx[7:0], sr);
    end
    chk(op_cnt, nops);
    chk(status, sr);
    fin(!p);
  endtask : er
  task automatic pg(input logic [8:0] o);
    logic ok;
    ok = !cust && o > 9'h00F;
    c1(8'h06);
    sr[1] = 1'h1;
    f({8'h02, 15'h0, o, 8'h3C}, 40);
    if (ok) begin
      nops++;
      sr[1:0] = 2'h1;
      chk({last_op.kind, last_op.otp, last_op.addr[8:0]}, {sfc_pkg::OP_PGM, 1'h1, o});
    end
    chk(op_cnt, nops);
    fin(ok);
  endtask : pg
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    int e;
    rst <= 1'h1;
    void'($urandom(82567));
    key = 8'($urandom);
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    repeat (4) @(posedge clk);
    #1;
    sr = sfc_pkg::SR_RESET;
    chk(status, sr);
    chk({sec, oe}, 5'h0);
    c1(8'h06);
    sr[1] = 1'h1;
    chk(status, sr);
    f({8'h04, 32'h0}, 9);
    chk(status, sr);
    c1(8'h04);
    sr[1] = 1'h0;
    chk(status, sr);
    for (int m = 0; m < 2; m++) begin
      h.mode3 = m[0];
      f({8'h05, 32'h0}, 8, 1, 0, 2);
      chk(rx[15:0], {sr, sr});
      f({8'h9F, 32'h0}, 8, 1, 0, 4);
      chk(rx, {MFR, TYP, DEV, 8'h00});
    end
    f({8'hFF, 32'h0}, 8, 1, 0, 1);
    chk({h.act_seen, h.oe_seen}, 2'h0);
    f({8'h05, 32'h0}, 8, 1, 0, 1);
    chk(h.act_seen, 1'h1);
    $display("command basics done");
    for (int c = 0; c < 16; c++) begin
      wrs({2'h0, c[3:0], 2'h0});
      e = (c > 0 && c < 7) ? 64 - (1 << (c - 1)) : (c > 8 && c < 15) ? 63 - (1 << (14 - c)) : 32;
      er(0);
      er(63);
      er(e);
      er((c < 7) ? e - 1 : e + 1);
    end
    $display("protect levels done");
    wrs(8'h40);
    a = 24'($urandom) & 24'h3FFF00;
    for (int k = 0; k < 4; k++) begin
      f({rdop[k], a, 8'h0}, 32, rdln[k], rddm[k], 4);
      chk(rx, {mem(a, 1'h0), mem(a + 1, 1'h0), mem(a + 2, 1'h0), mem(a + 3, 1'h0)});
    end
    $display("read modes done");
    wrs(8'hC0);
    h.wp = 1'h0;
    wrs(8'h00);
    h.wp = 1'h1;
    wrs(8'h80);
    h.wp = 1'h0;
    wrs(8'h00);
    h.wp = 1'h1;
    wrs(8'h00);
    $display("guard pin done");
    c1(8'hB1);
    sa = 1'h1;
    chk(sec, 1'h1);
    er(5);
    pg(9'h00F);
    pg(9'h010);
    f({8'h2B, 32'h0}, 8, 1, 0, 1);
    chk(rx[7:0], 8'h01);
    c1(8'h2F);
    cust = 1'h1;
    f({8'h2B, 32'h0}, 8, 1, 0, 1);
    chk(rx[7:0], 8'h03);
    pg(9'h1FF);
    c1(8'hC1);
    sa = 1'h0;
    chk(sec, 1'h0);
    f({8'h2B, 32'h0}, 8, 1, 0, 1);
    chk(rx[7:0], 8'h03);
    $display("secure area done");
    print_verdict;
  end
  initial begin
    #2000000;
    fail_count++;
    print_verdict;
  end
endmodule : test_serial_flash_cmd_protect
